// ==== rtl/jtb_bscan.sv ====
// boundary scan chain: capture, shift and update stages per cell
// assumes one-cycle enables from the tap on the same clock
`timescale 1ns/1ps
module jtb_bscan #(
    parameter int LEN = 8
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic capture_i,
    input wire logic shift_i,
    input wire logic update_i,
    input wire logic tdi_i,
    input wire logic [LEN-1:0] cap_i,
    output logic ser_o,
    output logic [LEN-1:0] upd_o
);

    logic [LEN-1:0] sr_q;
    logic [LEN-1:0] up_q;

    // dedicated cells, never in the system data path
    genvar g;
    for (g = 0; g < LEN; g++) begin : g_cell
        logic nxt;
        if (g == LEN - 1) begin : g_last
            assign nxt = tdi_i;
        end else begin : g_mid
            assign nxt = sr_q[g+1];
        end
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                sr_q[g] <= 1'b0;
            end else if (capture_i) begin
                sr_q[g] <= cap_i[g];
            end else if (shift_i) begin
                sr_q[g] <= nxt;
            end
        end
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                up_q[g] <= 1'b0;
            end else if (update_i) begin
                up_q[g] <= sr_q[g];
            end
        end
    end

    assign ser_o = sr_q[0];
    assign upd_o = up_q;

endmodule // jtb_bscan

// ==== rtl/jtb_pkg.sv ====
// constants and types shared by the test access port design
// assumes nothing beyond a SystemVerilog-2012 compiler
package jtb_pkg;

    localparam int IR_W = 4;
    localparam int ID_W = 32;

    localparam logic [3:0] OPC_EXTEST = 4'h0;
    localparam logic [3:0] OPC_INTSCAN = 4'h2;
    localparam logic [3:0] OPC_SAMPLE = 4'h4;
    localparam logic [3:0] OPC_HIGHZ = 4'h5;
    localparam logic [3:0] OPC_IDCODE = 4'h6;
    localparam logic [3:0] OPC_BYPASS = 4'hf;

    // value loaded into the instruction shifter on capture
    localparam logic [3:0] IR_CAPTURE = 4'h1;
    // instruction in effect after test logic reset
    localparam logic [3:0] IR_RESET = OPC_IDCODE;

    localparam int ID_VER_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MFR_LSB = 0;

    typedef enum logic [3:0] {
        ST_TLR, ST_RTI, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
        ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
        ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
    } jtb_state_t;

    typedef enum logic [2:0] {
        OP_EXTEST, OP_SAMPLE, OP_HIGHZ, OP_IDCODE, OP_BYPASS, OP_INTSCAN
    } jtb_op_t;

    function automatic jtb_op_t jtb_decode(input logic [3:0] ir);
        case (ir)
            OPC_EXTEST: return OP_EXTEST;
            OPC_SAMPLE: return OP_SAMPLE;
            OPC_HIGHZ: return OP_HIGHZ;
            OPC_IDCODE: return OP_IDCODE;
            OPC_INTSCAN: return OP_INTSCAN;
            default: return OP_BYPASS;
        endcase
    endfunction

endpackage

// ==== rtl/jtb_tap.sv ====
// test access port with instruction, bypass, id and boundary registers
// assumes tester pins arrive asynchronously; TCK well below CLK_I/4
// Operation
// - sixteen-state controller stepped by TCK, TMS
// - power-on reset puts controller in reset
// - four-bit instruction selects data register
// - undefined codes behave as bypass
// - EXTEST: boundary chain, drive and capture pins
// - SAMPLE: boundary chain, sample, preload, system runs
// - HIGHZ/BYPASS use bypass; HIGHZ floats outputs
// - IDCODE selects identification register
// - bypass is one shift stage
// - bypass selectable when idle
// - fixed 32-bit id: version, part, maker
// - maker code low, bit zero one
// - boundary cells chained TDI to TDO
// - four boundary cell kinds by pin function
// - boundary cells are dedicated test logic
// - parallel capture on TCK rising edge
// - test port idle during bus cycles
// - every signal pin in boundary chain
`timescale 1ns/1ps
module jtb_tap #(
    parameter int N_IN = 2,
    parameter int N_OUT = 2,
    parameter int N_IO = 4,
    // arbitrary identification values
    parameter logic [3:0] ID_VERSION = 4'h1,
    parameter logic [15:0] ID_PART = 16'h1234,
    parameter logic [11:0] ID_MFR = 12'h0a5
) (
    input wire logic CLK_I,
    input wire logic RST_N_I,
    input wire logic TCK_I,
    input wire logic TMS_I,
    input wire logic TDI_I,
    input wire logic TRST_N_I,
    output logic TDO_O,
    output logic TDO_OE_O,
    input wire logic BUS_ACTIVE_I,
    input wire logic [N_IN-1:0] PIN_IN_I,
    output logic [N_IN-1:0] CORE_IN_O,
    input wire logic [N_OUT-1:0] CORE_OUT_I,
    input wire logic CORE_OUT_OE_I,
    output logic [N_OUT-1:0] PIN_OUT_O,
    output logic PIN_OUT_OE_O,
    input wire logic [N_IO-1:0] PIN_IO_IN_I,
    output logic [N_IO-1:0] CORE_IO_IN_O,
    input wire logic [N_IO-1:0] CORE_IO_OUT_I,
    input wire logic [N_IO-1:0] CORE_IO_OE_I,
    output logic [N_IO-1:0] PIN_IO_OUT_O,
    output logic [N_IO-1:0] PIN_IO_OE_O,
    input wire logic SCAN_OUT_I,
    output logic SCAN_IN_O,
    output logic SCAN_EN_O,
    output logic SCAN_STEP_O
);

    localparam int BS_LEN = N_IN + N_OUT + 1 + 2 * N_IO;
    localparam int O_OUT = N_IN;
    localparam int O_OCT = N_IN + N_OUT;
    localparam int O_IO = O_OCT + 1;
    localparam int O_ICT = O_IO + N_IO;

    localparam logic [31:0] ID_VALUE = ({28'h0, ID_VERSION} << jtb_pkg::ID_VER_LSB)
        | ({16'h0, ID_PART} << jtb_pkg::ID_PART_LSB)
        | ({20'h0, ID_MFR[11:1], 1'b1} << jtb_pkg::ID_MFR_LSB);

    // power-on or tester reset; release is not resynchronised, so TRST
    // must rise while TCK is quiet
    logic tap_rst_n;
    assign tap_rst_n = RST_N_I & TRST_N_I;

    // two-stage synchronisers for tck, tms and tdi; trst is used unsynchronised
    logic tck_s1, tck_s2, tck_s3, tms_s1, tms_s2, tdi_s1, tdi_s2;
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            tck_s1 <= 1'b0;
            tck_s2 <= 1'b0;
            tck_s3 <= 1'b0;
            tms_s1 <= 1'b1;
            tms_s2 <= 1'b1;
            tdi_s1 <= 1'b1;
            tdi_s2 <= 1'b1;
        end else begin
            tck_s1 <= TCK_I;
            tck_s2 <= tck_s1;
            tck_s3 <= tck_s2;
            tms_s1 <= TMS_I;
            tms_s2 <= tms_s1;
            tdi_s1 <= TDI_I;
            tdi_s2 <= tdi_s1;
        end
    end

    // tck edges are ignored while the bridge runs bus cycles
    logic te_rise, te_fall;
    assign te_rise = tck_s2 & ~tck_s3 & ~BUS_ACTIVE_I;
    assign te_fall = ~tck_s2 & tck_s3 & ~BUS_ACTIVE_I;

    jtb_pkg::jtb_state_t state_q, state_d;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            jtb_pkg::ST_TLR: state_d = tms_s2 ? jtb_pkg::ST_TLR : jtb_pkg::ST_RTI;
            jtb_pkg::ST_RTI: state_d = tms_s2 ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_RTI;
            jtb_pkg::ST_SEL_DR: state_d = tms_s2 ? jtb_pkg::ST_SEL_IR : jtb_pkg::ST_CAP_DR;
            jtb_pkg::ST_CAP_DR: state_d = tms_s2 ? jtb_pkg::ST_EXIT1_DR : jtb_pkg::ST_SHIFT_DR;
            jtb_pkg::ST_SHIFT_DR: state_d = tms_s2 ? jtb_pkg::ST_EXIT1_DR : jtb_pkg::ST_SHIFT_DR;
            jtb_pkg::ST_EXIT1_DR: state_d = tms_s2 ? jtb_pkg::ST_UPD_DR : jtb_pkg::ST_PAUSE_DR;
            jtb_pkg::ST_PAUSE_DR: state_d = tms_s2 ? jtb_pkg::ST_EXIT2_DR : jtb_pkg::ST_PAUSE_DR;
            jtb_pkg::ST_EXIT2_DR: state_d = tms_s2 ? jtb_pkg::ST_UPD_DR : jtb_pkg::ST_SHIFT_DR;
            jtb_pkg::ST_UPD_DR: state_d = tms_s2 ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_RTI;
            jtb_pkg::ST_SEL_IR: state_d = tms_s2 ? jtb_pkg::ST_TLR : jtb_pkg::ST_CAP_IR;
            jtb_pkg::ST_CAP_IR: state_d = tms_s2 ? jtb_pkg::ST_EXIT1_IR : jtb_pkg::ST_SHIFT_IR;
            jtb_pkg::ST_SHIFT_IR: state_d = tms_s2 ? jtb_pkg::ST_EXIT1_IR : jtb_pkg::ST_SHIFT_IR;
            jtb_pkg::ST_EXIT1_IR: state_d = tms_s2 ? jtb_pkg::ST_UPD_IR : jtb_pkg::ST_PAUSE_IR;
            jtb_pkg::ST_PAUSE_IR: state_d = tms_s2 ? jtb_pkg::ST_EXIT2_IR : jtb_pkg::ST_PAUSE_IR;
            jtb_pkg::ST_EXIT2_IR: state_d = tms_s2 ? jtb_pkg::ST_UPD_IR : jtb_pkg::ST_SHIFT_IR;
            jtb_pkg::ST_UPD_IR: state_d = tms_s2 ? jtb_pkg::ST_SEL_DR : jtb_pkg::ST_RTI;
        endcase
    end

    always_ff @(posedge CLK_I or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            state_q <= jtb_pkg::ST_TLR;
        end else if (te_rise) begin
            state_q <= state_d;
        end
    end

    // instruction shifter and the instruction in effect
    logic [3:0] ir_sr_q, ir_q;
    always_ff @(posedge CLK_I or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_sr_q <= jtb_pkg::IR_CAPTURE;
        end else if (te_rise && state_q == jtb_pkg::ST_CAP_IR) begin
            ir_sr_q <= jtb_pkg::IR_CAPTURE;
        end else if (te_rise && state_q == jtb_pkg::ST_SHIFT_IR) begin
            ir_sr_q <= {tdi_s2, ir_sr_q[3:1]};
        end
    end

    always_ff @(posedge CLK_I or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_q <= jtb_pkg::IR_RESET;
        end else if (te_rise && state_q == jtb_pkg::ST_TLR) begin
            ir_q <= jtb_pkg::IR_RESET;
        end else if (te_fall && state_q == jtb_pkg::ST_UPD_IR) begin
            ir_q <= ir_sr_q;
        end
    end

    jtb_pkg::jtb_op_t op;
    assign op = jtb_pkg::jtb_decode(ir_q);

    logic cap_dr, shf_dr, upd_dr;
    assign cap_dr = te_rise && state_q == jtb_pkg::ST_CAP_DR;
    assign shf_dr = te_rise && state_q == jtb_pkg::ST_SHIFT_DR;
    assign upd_dr = te_fall && state_q == jtb_pkg::ST_UPD_DR;

    // bypass stage, the path for bypass, highz and undefined codes
    logic byp_q;
    always_ff @(posedge CLK_I or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            byp_q <= 1'b0;
        end else if (op == jtb_pkg::OP_BYPASS || op == jtb_pkg::OP_HIGHZ) begin
            if (cap_dr) begin
                byp_q <= 1'b0;
            end else if (shf_dr) begin
                byp_q <= tdi_s2;
            end
        end
    end

    logic [31:0] id_sr_q;
    always_ff @(posedge CLK_I or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            id_sr_q <= ID_VALUE;
        end else if (op == jtb_pkg::OP_IDCODE) begin
            if (cap_dr) begin
                id_sr_q <= ID_VALUE;
            end else if (shf_dr) begin
                id_sr_q <= {tdi_s2, id_sr_q[31:1]};
            end
        end
    end

    // pin input synchronisers feed both the core and the capture cells
    logic [N_IN-1:0] in_s1, in_s2;
    logic [N_IO-1:0] io_s1, io_s2;
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            in_s1 <= '0;
            in_s2 <= '0;
            io_s1 <= '0;
            io_s2 <= '0;
        end else begin
            in_s1 <= PIN_IN_I;
            in_s2 <= in_s1;
            io_s1 <= PIN_IO_IN_I;
            io_s2 <= io_s1;
        end
    end

    // cell kinds: input, output, output control, bidir with its control
    logic bs_on;
    logic [BS_LEN-1:0] bs_cap, bs_upd;
    logic bs_ser;
    assign bs_on = op == jtb_pkg::OP_EXTEST || op == jtb_pkg::OP_SAMPLE;
    assign bs_cap = {PIN_IO_OE_O, io_s2, PIN_OUT_OE_O, PIN_OUT_O, in_s2};

    jtb_bscan #(
        .LEN(BS_LEN)
    ) u_bscan (
        .clk_i(CLK_I),
        .rst_n_i(tap_rst_n),
        .capture_i(cap_dr && bs_on),
        .shift_i(shf_dr && bs_on),
        .update_i(upd_dr && bs_on),
        .tdi_i(tdi_s2),
        .cap_i(bs_cap),
        .ser_o(bs_ser),
        .upd_o(bs_upd)
    );

    // pin drivers; registered, so the system path gains one cycle
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            PIN_OUT_O <= '0;
            PIN_OUT_OE_O <= 1'b0;
            PIN_IO_OUT_O <= '0;
            PIN_IO_OE_O <= '0;
        end else if (op == jtb_pkg::OP_EXTEST) begin
            PIN_OUT_O <= bs_upd[O_OUT +: N_OUT];
            PIN_OUT_OE_O <= bs_upd[O_OCT];
            PIN_IO_OUT_O <= bs_upd[O_IO +: N_IO];
            PIN_IO_OE_O <= bs_upd[O_ICT +: N_IO];
        end else if (op == jtb_pkg::OP_HIGHZ) begin
            PIN_OUT_O <= CORE_OUT_I;
            PIN_OUT_OE_O <= 1'b0;
            PIN_IO_OUT_O <= CORE_IO_OUT_I;
            PIN_IO_OE_O <= '0;
        end else begin
            PIN_OUT_O <= CORE_OUT_I;
            PIN_OUT_OE_O <= CORE_OUT_OE_I;
            PIN_IO_OUT_O <= CORE_IO_OUT_I;
            PIN_IO_OE_O <= CORE_IO_OE_I;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            CORE_IN_O <= '0;
            CORE_IO_IN_O <= '0;
        end else begin
            CORE_IN_O <= in_s2;
            CORE_IO_IN_O <= io_s2;
        end
    end

    // internal scan: one step per TCK rise in shift-dr
    always_ff @(posedge CLK_I or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            SCAN_IN_O <= 1'b0;
            SCAN_EN_O <= 1'b0;
            SCAN_STEP_O <= 1'b0;
        end else begin
            SCAN_IN_O <= tdi_s2;
            SCAN_EN_O <= op == jtb_pkg::OP_INTSCAN;
            SCAN_STEP_O <= shf_dr && op == jtb_pkg::OP_INTSCAN;
        end
    end

    logic dr_ser;
    always_comb begin
        dr_ser = byp_q;
        unique case (op)
            jtb_pkg::OP_EXTEST, jtb_pkg::OP_SAMPLE: dr_ser = bs_ser;
            jtb_pkg::OP_IDCODE: dr_ser = id_sr_q[0];
            jtb_pkg::OP_INTSCAN: dr_ser = SCAN_OUT_I;
            jtb_pkg::OP_HIGHZ, jtb_pkg::OP_BYPASS: dr_ser = byp_q;
        endcase
    end

    // tdo moves only on falling tck, driven during shift states
    always_ff @(posedge CLK_I or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            TDO_O <= 1'b0;
            TDO_OE_O <= 1'b0;
        end else if (te_fall) begin
            TDO_O <= state_q == jtb_pkg::ST_SHIFT_IR ? ir_sr_q[0] : dr_ser;
            TDO_OE_O <= state_q == jtb_pkg::ST_SHIFT_IR || state_q == jtb_pkg::ST_SHIFT_DR;
        end
    end

    sequence s_cap_id;
        cap_dr && op == jtb_pkg::OP_IDCODE;
    endsequence

    sequence s_cap_byp;
        cap_dr && op == jtb_pkg::OP_BYPASS;
    endsequence

    a_reset_to_tlr: assert property (@(posedge CLK_I)
        !tap_rst_n |=> state_q == jtb_pkg::ST_TLR || !tap_rst_n)
        else $error("tap not in reset state after reset");
    a_state_holds: assert property (@(posedge CLK_I) disable iff (!tap_rst_n)
        !te_rise |=> $stable(state_q))
        else $error("state moved without tck rise");
    a_tlr_exit: assert property (@(posedge CLK_I) disable iff (!tap_rst_n)
        te_rise && state_q == jtb_pkg::ST_TLR && !tms_s2 |=> state_q == jtb_pkg::ST_RTI)
        else $error("reset state did not leave on tms low");
    a_unknown_bypass: assert property (@(posedge CLK_I) disable iff (!tap_rst_n)
        ir_q == 4'h3 |-> op == jtb_pkg::OP_BYPASS)
        else $error("undefined code not bypass");
    a_extest_drive: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (op == jtb_pkg::OP_EXTEST)[*2] |-> PIN_OUT_O == $past(bs_upd[O_OUT +: N_OUT]))
        else $error("extest not driving update cells");
    a_sample_passes: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        op == jtb_pkg::OP_SAMPLE |=> PIN_IO_OUT_O == $past(CORE_IO_OUT_I))
        else $error("sample disturbed system outputs");
    a_highz_float: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        op == jtb_pkg::OP_HIGHZ |=> !PIN_OUT_OE_O && PIN_IO_OE_O == '0)
        else $error("highz left an output enabled");
    a_id_capture: assert property (@(posedge CLK_I) disable iff (!tap_rst_n)
        s_cap_id |=> id_sr_q == ID_VALUE && id_sr_q[0])
        else $error("id capture wrong");
    a_byp_capture: assert property (@(posedge CLK_I) disable iff (!tap_rst_n)
        s_cap_byp |=> !byp_q)
        else $error("bypass capture not zero");
    a_tdo_on_fall: assert property (@(posedge CLK_I) disable iff (!tap_rst_n)
        !te_fall |=> $stable(TDO_O))
        else $error("tdo moved off falling tck");
    a_bus_quiet: assert property (@(posedge CLK_I) disable iff (!tap_rst_n)
        BUS_ACTIVE_I |=> $stable(state_q) && $stable(ir_q))
        else $error("tap moved during bus cycle");

endmodule // jtb_tap

// ==== rtl/placeholder_unused.sv ====
// intentionally empty
`timescale 1ns/1ps

// ==== tb/jtag_tap_boundary_scan_bench.sv ====
// self-checking bench for the test access port with a tester model on its pins
// assumes the package, the design and the tester model are compiled first
`timescale 1ns/1ps
module jtag_tap_boundary_scan_bench;
    localparam logic [3:0] ID_V = 4'h3; // arbitrary value
    localparam logic [15:0] ID_P = 16'h5a5a; // arbitrary value
    localparam logic [11:0] ID_M = 12'h0c2; // arbitrary value, bit zero left clear
    localparam logic [31:0] EXP_ID = {ID_V, ID_P, ID_M | 12'h001};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic tck, tms, tdi, trst_n, tdo, tdo_oe, pin_oe, got_v;
    logic bus_act = 1'b0;
    logic core_oe = 1'b0;
    logic [1:0] pin_in = '0, core_out = '0, core_in, pin_out;
    logic [3:0] io_in = '0, io_out = '0, io_oe = '0, core_io_in, pin_io_out, pin_io_oe;
    logic scan_out = 1'b0, scan_in, scan_en, scan_step;
    logic [63:0] got;
    logic [63:0] exp_q[$];
    int n_fail = 0;
    int total_checks = 0;
    int steps = 0;
    logic [7:0] scan_bits = '0;

    always #10 clk = ~clk;

    jtb_tap #(.ID_VERSION(ID_V), .ID_PART(ID_P), .ID_MFR(ID_M)) i_jtb_tap (
        .CLK_I(clk), .RST_N_I(rst_n), .TCK_I(tck), .TMS_I(tms), .TDI_I(tdi),
        .TRST_N_I(trst_n), .TDO_O(tdo), .TDO_OE_O(tdo_oe), .BUS_ACTIVE_I(bus_act),
        .PIN_IN_I(pin_in), .CORE_IN_O(core_in), .CORE_OUT_I(core_out),
        .CORE_OUT_OE_I(core_oe), .PIN_OUT_O(pin_out), .PIN_OUT_OE_O(pin_oe),
        .PIN_IO_IN_I(io_in), .CORE_IO_IN_O(core_io_in), .CORE_IO_OUT_I(io_out),
        .CORE_IO_OE_I(io_oe), .PIN_IO_OUT_O(pin_io_out), .PIN_IO_OE_O(pin_io_oe),
        .SCAN_OUT_I(scan_out), .SCAN_IN_O(scan_in), .SCAN_EN_O(scan_en),
        .SCAN_STEP_O(scan_step)
    );

    jtb_tester i_jtb_tester (
        .clk_i(clk), .tdo_i(tdo), .tck_o(tck), .tms_o(tms), .tdi_o(tdi),
        .trst_n_o(trst_n), .got_v_o(got_v), .got_o(got)
    );

    task automatic check_scan(input logic [63:0] e, input logic [63:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected scan out: expected %h seen %h", e, g);
        end
    endtask

    task automatic check_pin(input string what, input logic [15:0] g, input logic [15:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, e, g);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic load(input logic [3:0] op);
        exp_q.push_back(64'(jtb_pkg::IR_CAPTURE));
        i_jtb_tester.scan(1'b1, 4, 64'(op));
    endtask

    task automatic dr(input int n, input logic [63:0] din, input logic [63:0] e);
        exp_q.push_back(e);
        i_jtb_tester.scan(1'b0, n, din);
    endtask

    // oldest note is matched against each finished frame
    always @(posedge clk) begin
        if (got_v === 1'b1) begin
            if (exp_q.size() > 0)
                check_scan(exp_q.pop_front(), got);
            else begin
                n_fail++;
                $display("unexpected frame: expected none seen %h", got);
            end
        end
        if (scan_step === 1'b1) begin
            steps++;
            scan_bits = {scan_in, scan_bits[7:1]};
        end
    end

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        $display("unexpected run length: expected end seen timeout");
        summarize();
    end

    initial begin
        logic b;
        logic [63:0] r;
        logic [12:0] p;
        int k;
        k = $urandom(32'h3a03);
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        i_jtb_tester.tick(1'b0, 1'b0, b);
        dr(32, 64'h0, 64'(EXP_ID));
        core_oe <= 1'b1;
        io_oe <= 4'hf;
        // sample, extest and intscan get their own scenario below
        for (int op = 0; op < 16; op++) begin
            if (op == 0 || op == 2 || op == 4)
                continue;
            r = {48'h0, 16'($urandom())};
            load(4'(op));
            if (op == 6)
                dr(16, r, {48'h0, EXP_ID[15:0]});
            else
                dr(16, r, {48'h0, r[14:0], 1'b0});
            if (op == 5)
                check_pin("oe", 16'({pin_oe, pin_io_oe}), 16'h0);
            else if (op == 15)
                check_pin("oe", 16'({pin_oe, pin_io_oe}), 16'h1f);
        end
        pin_in <= 2'($urandom());
        io_in <= 4'($urandom());
        core_out <= 2'($urandom());
        io_out <= 4'($urandom());
        io_oe <= 4'($urandom());
        p = 13'($urandom());
        repeat (8) @(posedge clk);
        load(jtb_pkg::OPC_SAMPLE);
        dr(13, 64'(p), 64'({io_oe, io_in, 1'b1, core_out, pin_in}));
        check_pin("core_in", 16'(core_in), 16'(pin_in));
        check_pin("pin_out", 16'(pin_out), 16'(core_out));
        check_pin("core_io_in", 16'(core_io_in), 16'(io_in));
        load(jtb_pkg::OPC_EXTEST);
        check_pin("ext", 16'({pin_io_oe, pin_io_out, pin_oe, pin_out}), 16'(p[12:2]));
        dr(13, 64'(~p), 64'({p[12:9], io_in, p[4:2], pin_in}));
        check_pin("ext", 16'({pin_io_oe, pin_io_out, pin_oe, pin_out}),
            16'(11'(~p[12:2])));
        scan_out <= 1'b1;
        load(jtb_pkg::OPC_INTSCAN);
        check_pin("scan_en", 16'(scan_en), 16'h1);
        steps = 0;
        r = {56'h0, 8'($urandom())};
        dr(8, r, 64'hff);
        check_pin("steps", 16'(steps), 16'h8);
        check_pin("scan_in", 16'(scan_bits), 16'(r[7:0]));
        load(jtb_pkg::OPC_BYPASS);
        bus_act <= 1'b1;
        repeat (5) i_jtb_tester.tick(1'b1, 1'b0, b);
        bus_act <= 1'b0;
        dr(8, 64'h5a, 64'hb4);
        i_jtb_tester.half = 8;
        load(4'h9);
        dr(16, 64'h8001, 64'h0002);
        i_jtb_tester.half = 4;
        // three ways back to the reset state, each restoring the id instruction
        for (k = 0; k < 3; k++) begin
            load(jtb_pkg::OPC_BYPASS);
            if (k == 0)
                i_jtb_tester.trst_pulse();
            else if (k == 1)
                repeat (5) i_jtb_tester.tick(1'b1, 1'b0, b);
            else begin
                rst_n <= 1'b0;
                repeat (2) @(posedge clk);
                rst_n <= 1'b1;
                repeat (4) @(posedge clk);
            end
            check_pin("tdo_oe", 16'(tdo_oe), 16'h0);
            i_jtb_tester.tick(1'b0, 1'b0, b);
            dr(32, 64'h0, 64'(EXP_ID));
        end
        for (k = 0; k < 100 && exp_q.size() > 0; k++)
            @(posedge clk);
        if (exp_q.size() > 0) begin
            n_fail++;
            $display("unexpected notes left: expected 0 seen %0d", exp_q.size());
        end
        summarize();
    end
endmodule // jtag_tap_boundary_scan_bench

// ==== tb/jtb_tester.sv ====
// tester model for the test port pins: drives tck, tms, tdi and trst_n, samples tdo
// assumes one caller at a time; tck rests low between ticks and frames
`timescale 1ns/1ps
module jtb_tester (
    input wire logic clk_i,
    input wire logic tdo_i,
    output logic tck_o,
    output logic tms_o,
    output logic tdi_o,
    output logic trst_n_o,
    output logic got_v_o,
    output logic [63:0] got_o
);
    // clk cycles per tck phase; 4 gives the 160 ns period, larger is a slow tester
    int half = 4;

    initial begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        trst_n_o = 1'b1;
        got_v_o = 1'b0;
        got_o = '0;
    end

    // entered on a clk edge, so a tick lasts 2*half cycles; tdo is sampled just
    // before the rise, a cycle after the design moved it on the previous fall
    task automatic tick(input logic tms, input logic tdi, output logic tdo);
        tms_o <= tms;
        tdi_o <= tdi;
        repeat (half) @(posedge clk_i);
        tdo = tdo_i;
        tck_o <= 1'b1;
        repeat (half) @(posedge clk_i);
        tck_o <= 1'b0;
    endtask

    // one frame from run-test-idle back to run-test-idle, lsb first
    task automatic scan(input logic ir, input int n, input logic [63:0] din);
        logic b;
        got_o <= '0;
        tick(1'b1, 1'b0, b);
        if (ir)
            tick(1'b1, 1'b0, b);
        tick(1'b0, 1'b0, b);
        tick(1'b0, 1'b0, b);
        for (int i = 0; i < n; i++) begin
            tick(i == n - 1, din[i], b);
            got_o[i] <= b;
        end
        tick(1'b1, 1'b0, b);
        tick(1'b0, 1'b0, b);
        @(posedge clk_i);
        got_v_o <= 1'b1;
        @(posedge clk_i);
        got_v_o <= 1'b0;
    endtask

    // released only while tck is static, the reset release is not resynchronised
    task automatic trst_pulse();
        @(posedge clk_i);
        trst_n_o <= 1'b0;
        repeat (3) @(posedge clk_i);
        trst_n_o <= 1'b1;
        repeat (4) @(posedge clk_i);
    endtask
endmodule // jtb_tester
